// [shared/err_check_consts.svh]
/*
 Shared constants for the program error checker: task error codes and limits.
 Assumes it is included once per compilation unit; guarded against repeats.
*/
`ifndef ERR_CHECK_CONSTS_SVH
`define ERR_CHECK_CONSTS_SVH

`define ERR_NONE        16'h0000
`define ERR_NO_BLOCK    16'h0024
`define ERR_MCODE       16'h0025
`define ERR_NO_SPEED    16'h0026
`define ERR_ARC         16'h0027
`define ERR_OVERFLOW    16'h0029
`define ERR_DIV_ZERO    16'h0030
`define ERR_POS_RANGE   16'h0031
`define ERR_REG_RANGE   16'h0032
`define ERR_NESTING     16'h0034
`define ERR_NO_RETURN   16'h0035
`define ERR_NO_PROG_NUM 16'h0036
`define MCODE_MAX       32'sd999
`define MCODE_MIN       32'sd0
`define MCODE_RESET     10'h000
`define NEST_MAX        3'd5
`define NEST_ZERO       3'd0
`define NEST_ONE        3'd1

`endif

// [shared/err_check_pkg.sv]
/*
 Types shared by the program error checker modules.
 Assumes err_check_consts.svh supplies the numeric constants.
*/
package err_check_pkg;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_MOVE,
		OP_INTERP_LIN,
		OP_INTERP_CIRC,
		OP_MCODE,
		OP_ARITH,
		OP_SUBST,
		OP_SUB_JUMP,
		OP_SUB_END,
		OP_PROG_END
	} block_op_t;

	typedef logic [15:0] err_code_t;

endpackage

// [core/block_checker.sv]
/*
 Combinational check of one executed program block; yields the error code.
 Assumes the interpreter presents decoded block facts on the ports in one cycle.
*/
`timescale 1ns/100ps
`include "err_check_consts.svh"

module block_checker (
	input  wire err_check_pkg::block_op_t op,
	input  wire logic                     next_missing,
	input  wire logic                     block_has_speed,
	input  wire logic                     speed_seen,
	input  wire logic signed [31:0]       mcode_value,
	input  wire logic                     arc_impossible,
	input  wire logic                     conv_overflow,
	input  wire logic                     divisor_zero,
	input  wire logic                     pos_overflow,
	input  wire logic                     origin_unset,
	input  wire logic                     reg_overflow,
	input  wire logic [2:0]               nest_depth,
	output err_check_pkg::err_code_t      err_code
);
	import err_check_pkg::*;

	always_comb begin
		err_code = `ERR_NONE;
		unique case (op)
			OP_NOP, OP_PROG_END: begin
				err_code = `ERR_NONE;
			end
			OP_MOVE: begin
				if (conv_overflow)
					err_code = `ERR_OVERFLOW;
			end
			OP_INTERP_LIN, OP_INTERP_CIRC: begin
				if (!block_has_speed && !speed_seen)
					err_code = `ERR_NO_SPEED;
				else if (op == OP_INTERP_CIRC && arc_impossible)
					err_code = `ERR_ARC;
				else if (conv_overflow)
					err_code = `ERR_OVERFLOW;
			end
			OP_MCODE: begin
				if (mcode_value < `MCODE_MIN || mcode_value > `MCODE_MAX)
					err_code = `ERR_MCODE;
			end
			OP_ARITH: begin
				if (divisor_zero)
					err_code = `ERR_DIV_ZERO;
				else if (pos_overflow)
					err_code = `ERR_POS_RANGE;
				else if (reg_overflow)
					err_code = `ERR_REG_RANGE;
			end
			OP_SUBST: begin
				if (origin_unset)
					err_code = `ERR_POS_RANGE;
				else if (reg_overflow)
					err_code = `ERR_REG_RANGE;
			end
			OP_SUB_JUMP: begin
				if (nest_depth >= `NEST_MAX)
					err_code = `ERR_NESTING;
			end
			OP_SUB_END: begin
				if (nest_depth == `NEST_ZERO)
					err_code = `ERR_NO_RETURN;
			end
			default: begin
				err_code = `ERR_NONE;
			end
		endcase
		// A block other than program end with no successor fails, and its code wins over any other; nothing after it can run
		if (op != OP_PROG_END && next_missing)
			err_code = `ERR_NO_BLOCK;
	end

endmodule

// [core/motion_program_error_checker.sv]
/*
 Execution-time error checker for a two-task motion program interpreter.
 Assumes one clock, synchronous active-high reset, and host control bits that
 are synchronous to sys_clk. Each task presents one executed block at a time.
*/
`timescale 1ns/100ps
`include "err_check_consts.svh"

module motion_program_error_checker (
	input  wire logic                           sys_clk,
	input  wire logic                           srst,
	// Host control bits, one bit of each per task
	input  wire logic [1:0]                     prog_num_read,
	input  wire logic [1:0]                     cycle_start,
	input  wire logic [1:0]                     err_clear,
	// Executed block, one per task
	input  wire logic [1:0]                     blk_valid,
	input  wire err_check_pkg::block_op_t       blk_op_t1,
	input  wire err_check_pkg::block_op_t       blk_op_t2,
	input  wire logic [1:0]                     next_missing,
	input  wire logic [1:0]                     block_has_speed,
	input  wire logic signed [31:0]             mcode_value_t1,
	input  wire logic signed [31:0]             mcode_value_t2,
	input  wire logic [1:0]                     arc_impossible,
	input  wire logic [1:0]                     conv_overflow,
	input  wire logic [1:0]                     divisor_zero,
	input  wire logic [1:0]                     pos_overflow,
	input  wire logic [1:0]                     origin_unset,
	input  wire logic [1:0]                     reg_overflow,
	// Status
	output err_check_pkg::err_code_t            err_word_t1,
	output err_check_pkg::err_code_t            err_word_t2,
	output logic [1:0]                          task_running,
	output logic [1:0]                          mcode_out_valid,
	output logic [9:0]                          mcode_out_t1,
	output logic [9:0]                          mcode_out_t2,
	output logic [2:0]                          nest_depth_t1,
	output logic [2:0]                          nest_depth_t2
);
	import err_check_pkg::*;

	typedef enum logic [1:0] {
		TS_IDLE,
		TS_RUN,
		TS_ERROR
	} task_state_t;

	task_state_t state_ff [2];
	logic [1:0]  armed_ff;
	logic [1:0]  run_ff;
	logic [1:0]  speed_seen_ff;
	logic [2:0]  nest_ff [2];
	err_code_t   err_ff [2];
	logic [1:0]  mvalid_ff;
	logic [9:0]  mcode_ff [2];
	err_code_t   chk_err [2];
	block_op_t   op_sel [2];
	logic signed [31:0] mval_sel [2];

	// ----------------------------------------------------------------
	// Run state step, shared by the state and running flops
	// ----------------------------------------------------------------
	function automatic task_state_t step_state(
		input task_state_t cur,
		input logic        go,
		input logic        refuse,
		input logic        fail,
		input logic        done,
		input logic        clear
	);
		step_state = cur;
		unique case (cur)
			TS_IDLE: begin
				if (go)
					step_state = TS_RUN;
				else if (refuse)
					step_state = TS_ERROR;
			end
			TS_RUN: begin
				if (fail)
					step_state = TS_ERROR;
				else if (done)
					step_state = TS_IDLE;
			end
			TS_ERROR: begin
				// Halted until cleared or a valid restart
				if (clear)
					step_state = TS_IDLE;
				else if (go)
					step_state = TS_RUN;
			end
			default: begin
				step_state = TS_IDLE;
			end
		endcase
	endfunction

	assign op_sel[0]   = blk_op_t1;
	assign op_sel[1]   = blk_op_t2;
	assign mval_sel[0] = mcode_value_t1;
	assign mval_sel[1] = mcode_value_t2;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_task
			block_checker u_chk (
				.op              (op_sel[g]),
				.next_missing    (next_missing[g]),
				.block_has_speed (block_has_speed[g]),
				.speed_seen      (speed_seen_ff[g]),
				.mcode_value     (mval_sel[g]),
				.arc_impossible  (arc_impossible[g]),
				.conv_overflow   (conv_overflow[g]),
				.divisor_zero    (divisor_zero[g]),
				.pos_overflow    (pos_overflow[g]),
				.origin_unset    (origin_unset[g]),
				.reg_overflow    (reg_overflow[g]),
				.nest_depth      (nest_ff[g]),
				.err_code        (chk_err[g])
			);

			wire logic blk_fire  = (state_ff[g] == TS_RUN) && blk_valid[g];
			wire logic blk_fail  = blk_fire && (chk_err[g] != `ERR_NONE);
			wire logic blk_ok    = blk_fire && (chk_err[g] == `ERR_NONE);
			wire logic blk_done  = blk_ok && (op_sel[g] == OP_PROG_END);
			wire logic blk_mcode = blk_ok && (op_sel[g] == OP_MCODE);
			// Any start request made while the task is not running
			wire logic start_req = cycle_start[g] && (state_ff[g] != TS_RUN);
			wire logic start_ok  = start_req && armed_ff[g];
			// A start with no fresh program number read is refused
			wire logic bad_start = start_req && !armed_ff[g];

			// ----------------------------------------------------------
			// Task run state
			// ----------------------------------------------------------
			always_ff @(posedge sys_clk) begin
				if (srst)
					state_ff[g] <= TS_IDLE;
				else
					state_ff[g] <= step_state(state_ff[g], start_ok, bad_start, blk_fail,
						blk_done, err_clear[g]);
			end

			// Running flag is its own flop so the output needs no decode
			always_ff @(posedge sys_clk) begin
				if (srst)
					run_ff[g] <= 1'b0;
				else
					run_ff[g] <= step_state(state_ff[g], start_ok, bad_start, blk_fail,
						blk_done, err_clear[g]) == TS_RUN;
			end

			// ----------------------------------------------------------
			// Program number read latch
			// ----------------------------------------------------------
			// Consumed by each start so edits force a new read
			always_ff @(posedge sys_clk) begin
				if (srst)
					armed_ff[g] <= 1'b0;
				else if (prog_num_read[g])
					armed_ff[g] <= 1'b1;
				else if (start_req)
					armed_ff[g] <= 1'b0;
			end

			// ----------------------------------------------------------
			// Speed memory and nesting depth
			// ----------------------------------------------------------
			always_ff @(posedge sys_clk) begin
				if (srst || start_req)
					speed_seen_ff[g] <= 1'b0;
				else if (blk_ok && block_has_speed[g])
					speed_seen_ff[g] <= 1'b1;
			end

			always_ff @(posedge sys_clk) begin
				if (srst || start_req)
					nest_ff[g] <= `NEST_ZERO;
				else if (blk_ok && op_sel[g] == OP_SUB_JUMP)
					nest_ff[g] <= nest_ff[g] + `NEST_ONE;
				else if (blk_ok && op_sel[g] == OP_SUB_END)
					nest_ff[g] <= nest_ff[g] - `NEST_ONE;
			end

			// ----------------------------------------------------------
			// Error word, held until cleared, restarted or overwritten by a refused start
			// ----------------------------------------------------------
			always_ff @(posedge sys_clk) begin
				if (srst)
					err_ff[g] <= `ERR_NONE;
				else if (blk_fail)
					err_ff[g] <= chk_err[g];
				else if (bad_start)
					err_ff[g] <= `ERR_NO_PROG_NUM;
				else if (err_clear[g] || start_ok)
					err_ff[g] <= `ERR_NONE;
			end

			// ----------------------------------------------------------
			// M code output, only for in-range values
			// ----------------------------------------------------------
			always_ff @(posedge sys_clk) begin
				if (srst) begin
					mvalid_ff[g] <= 1'b0;
					mcode_ff[g]  <= `MCODE_RESET;
				end else begin
					mvalid_ff[g] <= blk_mcode;
					if (blk_mcode)
						mcode_ff[g] <= mval_sel[g][9:0];
				end
			end
		end
	endgenerate

	assign err_word_t1     = err_ff[0];
	assign err_word_t2     = err_ff[1];
	assign task_running    = run_ff;
	assign mcode_out_valid = mvalid_ff;
	assign mcode_out_t1    = mcode_ff[0];
	assign mcode_out_t2    = mcode_ff[1];
	assign nest_depth_t1   = nest_ff[0];
	assign nest_depth_t2   = nest_ff[1];

endmodule

// [test/host_ctrl_model.sv]
/* Host control bit model for the error checker.
 Assumes it shares sys_clk with the block. */
`timescale 1ns/100ps
// ----
// Host
// ----
module host_ctrl_model (
	input  wire logic       sys_clk,
	output logic      [1:0] prog_num_read,
	output logic      [1:0] cycle_start
);
	initial begin
		prog_num_read = 2'h0;
		cycle_start = 2'h0;
	end
	// Skipping the read step is how a refused start is provoked
	task automatic start(input int t, input logic arm);
		@(posedge sys_clk);
		prog_num_read[t] <= arm;
		@(posedge sys_clk);
		prog_num_read[t] <= 1'b0;
		cycle_start[t] <= 1'b1;
		@(posedge sys_clk);
		cycle_start[t] <= 1'b0;
	endtask
endmodule

// [test/motion_program_error_checker_monitor.sv]
/* Port checker for the error checker.
 Assumes it is bound to the top module. */
`timescale 1ns/100ps
`include "err_check_consts.svh"
// ----
// Checks
// ----
module motion_program_error_checker_monitor (
	input wire logic                     sys_clk,
	input wire logic                     srst,
	input wire logic [1:0]               err_clear,
	input wire logic [1:0]               cycle_start,
	input wire logic [1:0]               blk_valid,
	input wire err_check_pkg::block_op_t blk_op_t1,
	input wire err_check_pkg::block_op_t blk_op_t2,
	input wire logic [1:0]               next_missing,
	input wire logic [1:0]               divisor_zero,
	input wire logic signed [31:0]       mcode_value_t1,
	input wire err_check_pkg::err_code_t err_word_t1,
	input wire err_check_pkg::err_code_t err_word_t2,
	input wire logic [1:0]               task_running,
	input wire logic [1:0]               mcode_out_valid,
	input wire logic [9:0]               mcode_out_t1,
	input wire logic [2:0]               nest_depth_t1
);
	import err_check_pkg::*;
	logic v1;
	assign v1 = blk_valid[0] && task_running[0] && !next_missing[0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	mcode_pass_a: assert property (v1 && blk_op_t1 == OP_MCODE && mcode_value_t1 >= `MCODE_MIN
		&& mcode_value_t1 <= `MCODE_MAX |=> mcode_out_valid[0] && mcode_out_t1 == $past(mcode_value_t1[9:0]))
		else $error("m code not passed");
	mcode_block_a: assert property (v1 && blk_op_t1 == OP_MCODE && mcode_value_t1 > `MCODE_MAX
		|=> !mcode_out_valid[0] && err_word_t1 == `ERR_MCODE) else $error("m code not refused");
	div_zero_a: assert property (v1 && blk_op_t1 == OP_ARITH && divisor_zero[0]
		|=> err_word_t1 == `ERR_DIV_ZERO && !task_running[0]) else $error("divide not aborted");
	next_block_a: assert property (blk_valid[0] && task_running[0] && next_missing[0]
		&& blk_op_t1 != OP_PROG_END
		|=> err_word_t1 == `ERR_NO_BLOCK ##0 !task_running[0]) else $error("missing block unseen");
	nest_limit_a: assert property (v1 && blk_op_t1 == OP_SUB_JUMP && nest_depth_t1 == `NEST_MAX
		|=> err_word_t1 == `ERR_NESTING) else $error("nesting not limited");
	no_return_a: assert property (v1 && blk_op_t1 == OP_SUB_END && nest_depth_t1 == `NEST_ZERO
		|=> err_word_t1 == `ERR_NO_RETURN) else $error("return not refused");
	err_hold_a: assert property (err_word_t1 != `ERR_NONE && !task_running[0] && !err_clear[0]
		&& !cycle_start[0] |=> $stable(err_word_t1) && !task_running[0]) else $error("error lost");
	task2_word_a: assert property (blk_valid[1] && task_running[1] && next_missing[1]
		&& blk_op_t2 != OP_PROG_END
		|=> err_word_t2 == `ERR_NO_BLOCK && !task_running[1]) else $error("task two word wrong");
endmodule
bind motion_program_error_checker motion_program_error_checker_monitor i_mon (.sys_clk, .srst,
	.err_clear, .cycle_start, .blk_valid, .blk_op_t1, .blk_op_t2, .next_missing, .divisor_zero,
	.mcode_value_t1, .err_word_t1, .err_word_t2, .task_running, .mcode_out_valid,
	.mcode_out_t1, .nest_depth_t1);

// [test/motion_program_error_checker_test.sv]
/* Self-checking bench for the error checker.
 Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`include "err_check_consts.svh"
// ----
// Bench
// ----
module motion_program_error_checker_test;
	import err_check_pkg::*;
	logic sys_clk, srst;
	logic [1:0] prog_num_read, cycle_start, err_clear, blk_valid, next_missing, block_has_speed;
	logic [1:0] arc_impossible, conv_overflow, divisor_zero, pos_overflow, origin_unset;
	logic [1:0] reg_overflow, task_running, mcode_out_valid;
	block_op_t blk_op_t1, blk_op_t2;
	logic signed [31:0] mcode_value_t1, mcode_value_t2;
	err_code_t err_word_t1, err_word_t2;
	err_code_t exp_w [2];
	logic [9:0] mcode_out_t1, mcode_out_t2;
	logic [2:0] nest_depth_t1, nest_depth_t2;
	logic [31:0] q [$];
	logic [31:0] last;
	logic [9:0] mq [$];
	int failures, comparisons;
	host_ctrl_model i_host (.sys_clk, .prog_num_read, .cycle_start);
	motion_program_error_checker i_dut (.sys_clk, .srst, .prog_num_read, .cycle_start, .err_clear,
		.blk_valid, .blk_op_t1, .blk_op_t2, .next_missing, .block_has_speed, .mcode_value_t1,
		.mcode_value_t2, .arc_impossible, .conv_overflow, .divisor_zero, .pos_overflow,
		.origin_unset, .reg_overflow, .err_word_t1, .err_word_t2, .task_running,
		.mcode_out_valid, .mcode_out_t1, .mcode_out_t2, .nest_depth_t1, .nest_depth_t2);
	task check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Facts in f: next, speed, arc, conv, div, pos, origin, reg from bit 7 down
	task blk(input int t, input block_op_t op, input logic [7:0] f, input logic signed [31:0] m);
		@(posedge sys_clk);
		blk_valid[t] <= 1'b1;
		blk_op_t1 <= op;
		blk_op_t2 <= op;
		mcode_value_t1 <= m;
		mcode_value_t2 <= m;
		{next_missing[t], block_has_speed[t], arc_impossible[t], conv_overflow[t],
			divisor_zero[t], pos_overflow[t], origin_unset[t], reg_overflow[t]} <= f;
	endtask
	task drain;
		for (int i = 0; i < 20 && q.size() > 0; i++)
			@(posedge sys_clk);
		if (q.size() > 0) begin
			failures++;
			final_report;
		end
	endtask
	task clr(input int t);
		@(posedge sys_clk);
		err_clear[t] <= 1'b1;
		exp_w[t] = `ERR_NONE;
		q.push_back({exp_w[1], exp_w[0]});
		@(posedge sys_clk);
		err_clear[t] <= 1'b0;
		drain;
		$display("test done task %0d", t);
	endtask
	// A halted task must ignore the trailing block
	task one(input int t, input block_op_t op, input logic [7:0] f, input logic signed [31:0] m,
		input err_code_t code, input int pre);
		i_host.start(t, 1'b1);
		for (int i = 0; i < pre; i++)
			blk(t, OP_SUB_JUMP, 8'h40, 0);
		exp_w[t] = code;
		q.push_back({exp_w[1], exp_w[0]});
		blk(t, op, f, m);
		blk(t, OP_ARITH, 8'h88, 0);
		@(posedge sys_clk);
		blk_valid[t] <= 1'b0;
		drain;
		clr(t);
	endtask
	always @(negedge sys_clk) begin
		if (!srst && {err_word_t2, err_word_t1} !== last) begin
			last = {err_word_t2, err_word_t1};
			check(last, q.size() ? q.pop_front() : ~last);
		end
		if (mcode_out_valid[0] === 1'b1)
			check(mcode_out_t1, mq.size() ? mq.pop_front() : ~mcode_out_t1);
		if (mcode_out_valid[1] === 1'b1)
			check(mcode_out_t2, mq.size() ? mq.pop_front() : ~mcode_out_t2);
	end
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		logic signed [31:0] m;
		srst = 1'b1;
		{err_clear, blk_valid, next_missing, block_has_speed, arc_impossible} = 10'h0;
		{conv_overflow, divisor_zero, pos_overflow, origin_unset, reg_overflow} = 10'h0;
		blk_op_t1 = OP_NOP;
		blk_op_t2 = OP_NOP;
		{mcode_value_t1, mcode_value_t2} = 64'h0;
		exp_w = '{default: 16'h0};
		last = 32'h0;
		void'($urandom(32'hc37c8bf3));
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		one(0, OP_INTERP_LIN, 8'h00, 0, `ERR_NO_SPEED, 0);
		one(0, OP_INTERP_CIRC, 8'h7c, 0, `ERR_ARC, 0);
		one(0, OP_MOVE, 8'h50, 0, `ERR_OVERFLOW, 0);
		one(0, OP_ARITH, 8'h0d, 0, `ERR_DIV_ZERO, 0);
		one(0, OP_ARITH, 8'h05, 0, `ERR_POS_RANGE, 0);
		one(0, OP_SUBST, 8'h03, 0, `ERR_POS_RANGE, 0);
		one(0, OP_SUBST, 8'h01, 0, `ERR_REG_RANGE, 0);
		one(0, OP_ARITH, 8'h88, 0, `ERR_NO_BLOCK, 0);
		one(0, OP_MCODE, 8'h00, 1000, `ERR_MCODE, 0);
		one(0, OP_MCODE, 8'h00, -1, `ERR_MCODE, 0);
		one(0, OP_SUB_END, 8'h00, 0, `ERR_NO_RETURN, 0);
		one(0, OP_SUB_JUMP, 8'h40, 0, `ERR_NESTING, 5);
		one(1, OP_ARITH, 8'h80, 0, `ERR_NO_BLOCK, 0);
		exp_w[0] = `ERR_NO_PROG_NUM;
		q.push_back({exp_w[1], exp_w[0]});
		i_host.start(0, 1'b0);
		drain;
		check(task_running[0], 1'b0);
		clr(0);
		i_host.start(0, 1'b1);
		blk(0, OP_INTERP_LIN, 8'h40, 0);
		blk(0, OP_INTERP_LIN, 8'h00, 0);
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 999 : (i == 1) ? 0 : $urandom % 1000;
			mq.push_back(m[9:0]);
			blk(0, OP_MCODE, 8'h00, m);
		end
		blk(0, OP_PROG_END, 8'h00, 0);
		@(posedge sys_clk);
		blk_valid[0] <= 1'b0;
		// Task 2 runs one jump and one M code on its own outputs
		i_host.start(1, 1'b1);
		blk(1, OP_SUB_JUMP, 8'h40, 0);
		m = $urandom % 1000;
		mq.push_back(m[9:0]);
		blk(1, OP_MCODE, 8'h00, m);
		blk(1, OP_PROG_END, 8'h00, 0);
		@(posedge sys_clk);
		blk_valid[1] <= 1'b0;
		repeat (2) @(posedge sys_clk);
		check({mq.size() == 0, task_running, q.size() == 0, nest_depth_t2, nest_depth_t1},
			{1'b1, 2'b00, 1'b1, `NEST_ONE, `NEST_ZERO});
		$display("test done m codes");
		final_report;
	end
endmodule
